// >>> core/adc_post_pkg.sv
// shared constants, register map, coefficient tables and carrier types
// assumes one 40 MHz clock and a 32-bit classic wishbone register bus
package adc_post_pkg;

  localparam int NUM_CH   = 8;
  localparam int DATA_W   = 12;
  localparam int NUM_COEF = 12;
  localparam int NUM_TAPS = 24;
  localparam int ACC_W    = 32;
  localparam int ADR_W    = 10;
  localparam int SCALE_SH = 11;
  localparam int HPF_FRAC = 16;

  // register indices, byte address is four times the index
  localparam logic [7:0] CTRL_IDX   = 8'h29;
  localparam logic [7:0] CHCFG_IDX  = 8'h30;
  localparam logic [7:0] AVGSEL_IDX = 8'h38;
  localparam logic [7:0] STATUS_IDX = 8'h39;
  localparam logic [7:0] COEF_IDX   = 8'h5A;
  localparam int         COEF_REGS  = NUM_CH * NUM_COEF;

  // control register fields
  localparam int FIR_ON_BIT  = 0;
  localparam int AVG_ON_BIT  = 1;
  localparam int DEC_LSB     = 4;
  // per-channel config fields
  localparam int RESP_LSB    = 0;
  localparam int ODD_BIT     = 3;
  localparam int CH_ON_BIT   = 4;
  localparam int CORNER_LSB  = 10;
  // coefficient register fields
  localparam int SRC_BIT     = 15;

  localparam logic [15:0] CTRL_RST   = 16'h0000;
  localparam logic [15:0] CHCFG_RST  = 16'h0000;
  localparam logic [15:0] AVGSEL_RST = 16'h0000;
  localparam logic [15:0] COEF_RST   = 16'h0000;

  typedef enum logic [2:0] {
    DEC_BY2  = 3'b000,
    DEC_BY4  = 3'b001,
    DEC_NONE = 3'b011,
    DEC_BY8  = 3'b100
  } dec_code_t;

  typedef logic signed [DATA_W-1:0] coef_t;
  typedef coef_t [NUM_COEF-1:0] coef_set_t;

  typedef struct packed {
    logic       fir_on;
    logic       odd;
    logic       nodec;
    logic [4:0] corner;
  } chan_cfg_t;

  typedef struct packed {
    logic                          valid;
    logic [NUM_CH-1:0][DATA_W-1:0] word;
  } sample_bus_t;

  typedef sample_bus_t lane_bus_t;

  localparam coef_t LP2_TAB [NUM_COEF] = '{12'sd3, 12'sd0, 12'sd5, 12'sd1, -12'sd27, -12'sd2,
    12'sd73, 12'sd3, -12'sd178, -12'sd4, 12'sd636, 12'sd1024};
  localparam coef_t HP2_TAB [NUM_COEF] = '{-12'sd22, -12'sd65, -12'sd52, 12'sd30, 12'sd66,
    -12'sd35, -12'sd107, 12'sd38, 12'sd202, -12'sd41, -12'sd644, 12'sd1061};
  localparam coef_t LP4_TAB [NUM_COEF] = '{-12'sd17, -12'sd50, 12'sd71, 12'sd46, 12'sd24,
    -12'sd42, -12'sd100, -12'sd97, 12'sd8, 12'sd202, 12'sd414, 12'sd554};
  localparam coef_t BA4_TAB [NUM_COEF] = '{-12'sd7, 12'sd19, -12'sd47, 12'sd127, 12'sd73,
    12'sd0, 12'sd86, 12'sd117, -12'sd190, -12'sd464, -12'sd113, 12'sd526};
  localparam coef_t BB4_TAB [NUM_COEF] = '{-12'sd34, -12'sd34, -12'sd101, 12'sd43, 12'sd58,
    -12'sd28, -12'sd5, -12'sd179, 12'sd294, 12'sd86, -12'sd563, 12'sd352};
  localparam coef_t HP4_TAB [NUM_COEF] = '{12'sd40, -12'sd15, -12'sd95, 12'sd22, -12'sd8,
    -12'sd81, 12'sd106, -12'sd62, -12'sd97, 12'sd310, -12'sd501, 12'sd575};

  function automatic logic [DATA_W-1:0] sat_word(input logic signed [ACC_W-1:0] v);
    logic signed [ACC_W-1:0] hi;
    logic signed [ACC_W-1:0] lo;
    hi = ACC_W'((1 << (DATA_W - 1)) - 1);
    lo = -hi - ACC_W'(1);
    if (v > hi)
      sat_word = hi[DATA_W-1:0];
    else if (v < lo)
      sat_word = lo[DATA_W-1:0];
    else
      sat_word = v[DATA_W-1:0];
  endfunction

endpackage

// >>> core/fir_channel.sv
// one channel: dc-removal high-pass, then 24/23/12-tap symmetric fir
// assumes coefficients and config are stable while samples stream
`timescale 1ns/10ps
module fir_channel
  import adc_post_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              valid_i,
  input  wire logic [DATA_W-1:0] word_i,
  input  wire logic              fire_i,
  input  wire chan_cfg_t         cfg_i,
  input  wire coef_set_t         coef_i,
  output logic [DATA_W-1:0]      word_o,
  output logic                   valid_o
);

  logic signed [ACC_W-1:0]  dc_reg;
  logic signed [ACC_W-1:0]  x_ext;
  logic signed [ACC_W-1:0]  hp_wide;
  logic        [DATA_W-1:0] hp_word;
  logic        [DATA_W-1:0] line_reg [NUM_TAPS-1];
  logic signed [ACC_W-1:0]  sum;
  logic signed [ACC_W-1:0]  scaled;

  assign x_ext   = ACC_W'(signed'(word_i));
  assign hp_wide = x_ext - (dc_reg >>> HPF_FRAC);
  assign hp_word = (cfg_i.corner == 5'h0_0) ? word_i : sat_word(hp_wide);

  // running dc estimate, corner code sets the leak
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dc_reg <= '0;
    else if (valid_i && cfg_i.corner != 5'h0_0)
      dc_reg <= dc_reg + (((x_ext <<< HPF_FRAC) - dc_reg) >>> cfg_i.corner);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int k = 0; k < NUM_TAPS - 1; k++)
        line_reg[k] <= '0;
    end
    else if (valid_i)
    begin
      line_reg[0] <= hp_word;
      for (int k = 1; k < NUM_TAPS - 1; k++)
        line_reg[k] <= line_reg[k-1];
    end
  end

  // tap k weights x(n-k); symmetric folding per mode
  always_comb
  begin
    coef_t                   w;
    logic signed [ACC_W-1:0] tap;
    w   = '0;
    tap = '0;
    sum = '0;
    for (int k = 0; k < NUM_TAPS; k++)
    begin
      tap = (k == 0) ? x_of(hp_word) : x_of(line_reg[(k == 0) ? 0 : k - 1]);
      if (cfg_i.nodec)
        w = (k < 6) ? coef_i[6 + k] : (k < 12) ? coef_i[17 - k] : coef_t'(0);
      else if (cfg_i.odd)
        w = (k < 12) ? coef_i[k] : (k < 23) ? coef_i[22 - k] : coef_t'(0);
      else
        w = (k < 12) ? coef_i[k] : coef_i[23 - k];
      sum = sum + ACC_W'(w) * tap;
    end
  end

  assign scaled = sum >>> SCALE_SH;

  function automatic logic signed [ACC_W-1:0] x_of(input logic [DATA_W-1:0] v);
    x_of = ACC_W'(signed'(v));
  endfunction

  // one word per fire; bypass passes every sample
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      word_o  <= '0;
      valid_o <= 1'b0;
    end
    else
    begin
      valid_o <= valid_i && (fire_i || !cfg_i.fir_on);
      if (valid_i && cfg_i.fir_on && fire_i)
        word_o <= sat_word(scaled);
      else if (valid_i && !cfg_i.fir_on)
        word_o <= hp_word;
    end
  end

endmodule

// >>> core/lane_avg.sv
// places two- or four-channel averages on chosen serial output lanes
// assumes all channel words belong to the same conversion instant
`timescale 1ns/10ps
module lane_avg
  import adc_post_pkg::*;
(
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire logic                          valid_i,
  input  wire logic [NUM_CH-1:0][DATA_W-1:0] word_i,
  input  wire logic                          avg_on_i,
  input  wire logic [2*NUM_CH-1:0]           sel_i,
  output lane_bus_t                          lanes_o
);

  logic [NUM_CH-1:0][DATA_W-1:0] lane_next;

  function automatic logic [DATA_W-1:0] avg2(input logic [DATA_W-1:0] a, b);
    logic signed [DATA_W:0] s;
    s    = (DATA_W+1)'(signed'(a)) + (DATA_W+1)'(signed'(b));
    avg2 = DATA_W'(s >>> 1);
  endfunction

  function automatic logic [DATA_W-1:0] avg4(input logic [DATA_W-1:0] a, b, c, d);
    logic signed [DATA_W+1:0] s;
    s    = (DATA_W+2)'(signed'(a)) + (DATA_W+2)'(signed'(b))
         + (DATA_W+2)'(signed'(c)) + (DATA_W+2)'(signed'(d));
    avg4 = DATA_W'(s >>> 2);
  endfunction

  for (genvar g = 0; g < 2; g++)
  begin : grp
    localparam int B = 4 * g;
    logic [DATA_W-1:0] pa;
    logic [DATA_W-1:0] pb;
    logic [DATA_W-1:0] q;
    logic [1:0]        s0;
    logic [1:0]        s1;
    logic [1:0]        s2;
    logic [1:0]        s3;
    assign pa = avg2(word_i[B], word_i[B+1]);
    assign pb = avg2(word_i[B+2], word_i[B+3]);
    assign q  = avg4(word_i[B], word_i[B+1], word_i[B+2], word_i[B+3]);
    assign s0 = avg_on_i ? sel_i[2*B+1:2*B] : 2'b00;
    assign s1 = avg_on_i ? sel_i[2*B+3:2*B+2] : 2'b00;
    assign s2 = avg_on_i ? sel_i[2*B+5:2*B+4] : 2'b00;
    assign s3 = avg_on_i ? sel_i[2*B+7:2*B+6] : 2'b00;
    assign lane_next[B]   = (s0 == 2'b10) ? pa : (s0 == 2'b11) ? q : word_i[B];
    assign lane_next[B+1] = (s1 == 2'b11) ? pb : word_i[B+1];
    assign lane_next[B+2] = (s2 == 2'b11) ? pa : word_i[B+2];
    assign lane_next[B+3] = (s3 == 2'b10) ? pb : (s3 == 2'b11) ? q : word_i[B+3];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      lanes_o <= '0;
    else
    begin
      lanes_o.valid <= valid_i;
      if (valid_i)
        lanes_o.word <= lane_next;
    end
  end

endmodule

// >>> core/adc_post_top.sv
// adc post-processing: register file, decimation timing, eight fir channels, averaging
// assumes a classic wishbone master and one sample word set per valid strobe
`timescale 1ns/10ps

module adc_post_top
  import adc_post_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  input  wire sample_bus_t      samples_i,
  output lane_bus_t             lanes_o
);

  logic [15:0]       ctrl_reg;
  logic [15:0]       chcfg_reg [NUM_CH];
  logic [15:0]       avgsel_reg;
  logic [15:0]       coef_mem  [COEF_REGS];
  logic [2:0]        dec_cnt_reg;
  logic [2:0]        dec_last;
  logic              dec_fire;
  logic              fir_block_on;
  logic              averaging_global_on;
  dec_code_t         decimation_factor_code;
  logic              req;
  logic              wr_req;
  logic [7:0]        idx;
  logic [7:0]        coef_off;
  logic              hit_coef;
  logic              hit_chcfg;
  logic [15:0]       wr_mask;
  logic [31:0]       rd_next;
  logic [NUM_CH-1:0] ch_active;
  logic [NUM_CH-1:0][DATA_W-1:0] ch_word;
  logic [NUM_CH-1:0]             ch_valid;

  // bus request decode
  assign req       = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_req    = req && wb_we_i;
  assign idx       = wb_adr_i[ADR_W-1:2];
  assign coef_off  = idx - COEF_IDX;
  assign hit_coef  = (idx >= COEF_IDX) && (idx < COEF_IDX + 8'(COEF_REGS));
  assign hit_chcfg = (idx >= CHCFG_IDX) && (idx < CHCFG_IDX + 8'(NUM_CH));
  assign wr_mask   = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  assign fir_block_on           = ctrl_reg[FIR_ON_BIT];
  assign averaging_global_on    = ctrl_reg[AVG_ON_BIT];
  assign decimation_factor_code = dec_code_t'(ctrl_reg[DEC_LSB+2:DEC_LSB]);

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [15:0] m);
    merge = (old & ~m) | (d[15:0] & m);
  endfunction

  // single-cycle ack, one answer per request, registered in the cycle after it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= req;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_reg   <= CTRL_RST;
      avgsel_reg <= AVGSEL_RST;
    end
    else if (wr_req && idx == CTRL_IDX)
      ctrl_reg <= merge(ctrl_reg, wb_dat_i, wr_mask);
    else if (wr_req && idx == AVGSEL_IDX)
      avgsel_reg <= merge(avgsel_reg, wb_dat_i, wr_mask);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int c = 0; c < NUM_CH; c++)
        chcfg_reg[c] <= CHCFG_RST;
    end
    else if (wr_req && hit_chcfg)
      chcfg_reg[idx[2:0]] <= merge(chcfg_reg[idx[2:0]], wb_dat_i, wr_mask);
  end

  // custom coefficients: bit 15 source select, bits 11:0 signed value
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int r = 0; r < COEF_REGS; r++)
        coef_mem[r] <= COEF_RST;
    end
    else if (wr_req && hit_coef)
      coef_mem[coef_off[6:0]] <= merge(coef_mem[coef_off[6:0]], wb_dat_i, wr_mask)
                                 & 16'h8_FFF;
  end

  // read mux, unmapped offsets read zero
  always_comb
  begin
    rd_next = '0;
    if (hit_coef)
      rd_next[15:0] = coef_mem[coef_off[6:0]];
    else if (hit_chcfg)
      rd_next[15:0] = chcfg_reg[idx[2:0]];
    else if (idx == CTRL_IDX)
      rd_next[15:0] = ctrl_reg;
    else if (idx == AVGSEL_IDX)
      rd_next[15:0] = avgsel_reg;
    else if (idx == STATUS_IDX)
      rd_next[15:0] = {ch_active, 5'h0_0, dec_cnt_reg};
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= '0;
    else if (req && !wb_we_i)
      wb_dat_o <= rd_next;
  end

  // decimation phase shared by all channels
  always_comb
  begin
    case (decimation_factor_code)
      DEC_BY2:  dec_last = 3'h1;
      DEC_BY4:  dec_last = 3'h3;
      DEC_BY8:  dec_last = 3'h7;
      DEC_NONE: dec_last = 3'h0;
      default:  dec_last = 3'h0;
    endcase
  end

  assign dec_fire = (dec_cnt_reg == dec_last);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dec_cnt_reg <= '0;
    else if (wr_req && idx == CTRL_IDX)
      dec_cnt_reg <= '0;
    else if (samples_i.valid)
      dec_cnt_reg <= dec_fire ? 3'h0 : dec_cnt_reg + 3'h1;
  end

  // built-in coefficient lookup by response code
  function automatic coef_t builtin(input logic [2:0] code, input int i);
    case (code)
      3'b000:  builtin = LP2_TAB[i];
      3'b001:  builtin = HP2_TAB[i];
      3'b010:  builtin = LP4_TAB[i];
      3'b011:  builtin = BA4_TAB[i];
      3'b100:  builtin = BB4_TAB[i];
      3'b101:  builtin = HP4_TAB[i];
      default: builtin = '0;
    endcase
  endfunction

  for (genvar c = 0; c < NUM_CH; c++)
  begin : chan
    coef_set_t coefs;
    chan_cfg_t cfg;

    for (genvar i = 0; i < NUM_COEF; i++)
    begin : tap
      localparam int R = c * NUM_COEF + i;
      assign coefs[i] = coef_mem[R][SRC_BIT] ? coef_t'(coef_mem[R][11:0])
                      : builtin(chcfg_reg[c][RESP_LSB+2:RESP_LSB], i);
    end

    assign cfg.fir_on = fir_block_on && chcfg_reg[c][CH_ON_BIT];
    assign cfg.odd    = chcfg_reg[c][ODD_BIT];
    assign cfg.nodec  = (decimation_factor_code == DEC_NONE);
    assign cfg.corner = chcfg_reg[c][CORNER_LSB+4:CORNER_LSB];
    assign ch_active[c] = cfg.fir_on;

    fir_channel u_fir
    (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .valid_i (samples_i.valid),
      .word_i  (samples_i.word[c]),
      .fire_i  (dec_fire),
      .cfg_i   (cfg),
      .coef_i  (coefs),
      .word_o  (ch_word[c]),
      .valid_o (ch_valid[c])
    );
  end

  lane_avg u_avg
  (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .valid_i  (|ch_valid),
    .word_i   (ch_word),
    .avg_on_i (averaging_global_on),
    .sel_i    (avgsel_reg),
    .lanes_o  (lanes_o)
  );

endmodule

// >>> sim/adc_post_monitor.sv
// checker on the top ports of the adc post-processing block
// assumes registers are written only while no samples stream
`timescale 1ns/10ps
module adc_post_monitor
  import adc_post_pkg::*;
(
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0]       wb_sel_i,
  input wire logic [31:0]      wb_dat_i,
  input wire logic [31:0]      wb_dat_o,
  input wire logic             wb_ack_o,
  input wire sample_bus_t      samples_i,
  input wire lane_bus_t        lanes_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [7:0]                    idx;
  logic                          wr;
  logic                          unmapped;
  logic [15:0]                   ctrl_reg;
  logic [15:0]                   sel_reg;
  logic [7:0]                    cidx_reg;
  logic [15:0]                   cval_reg;
  logic [NUM_CH-1:0][DATA_W-1:0] s1_reg;
  logic [NUM_CH-1:0][DATA_W-1:0] s2_reg;
  logic [13:0]                   pair_sum;
  logic [13:0]                   quad_sum;
  function automatic logic [13:0] sx(input logic [11:0] a);
    return {{2{a[11]}}, a};
  endfunction
  assign idx = wb_adr_i[9:2];
  assign wr = wb_ack_o && wb_we_i;
  assign unmapped = !(idx == CTRL_IDX || idx == AVGSEL_IDX || idx == STATUS_IDX
    || (idx >= CHCFG_IDX && idx < CHCFG_IDX + 8)
    || (idx >= COEF_IDX && idx < COEF_IDX + COEF_REGS));
  assign pair_sum = sx(s2_reg[0]) + sx(s2_reg[1]);
  assign quad_sum = sx(s2_reg[4]) + sx(s2_reg[5]) + sx(s2_reg[6]) + sx(s2_reg[7]);
  // shadow of the mode registers
  always_ff @(posedge clk_i)
    if (rst_i)
    begin
      ctrl_reg <= 16'h0000;
      sel_reg  <= 16'h0000;
    end
    else if (wr && idx == CTRL_IDX)
      ctrl_reg <= wb_dat_i[15:0];
    else if (wr && idx == AVGSEL_IDX)
      sel_reg <= wb_dat_i[15:0];
  // last coefficient written
  always_ff @(posedge clk_i)
    if (rst_i)
    begin
      cidx_reg <= 8'h00;
      cval_reg <= 16'h0000;
    end
    else if (wr && idx >= COEF_IDX && idx < COEF_IDX + COEF_REGS)
    begin
      cidx_reg <= idx;
      cval_reg <= wb_dat_i[15:0] & 16'h8fff;
    end
  // samples two edges back
  always_ff @(posedge clk_i)
  begin
    s1_reg <= samples_i.word;
    s2_reg <= s1_reg;
  end
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_next_cycle: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("request not acked next cycle");
  a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_upper_half_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read data not zero");
  a_unmapped_zero: assert property ((wb_ack_o && !wb_we_i && unmapped) |-> wb_dat_o == 0)
    else $error("unmapped read not zero");
  a_coef_readback: assert property ((wb_ack_o && !wb_we_i && cidx_reg != 8'h00
    && idx == cidx_reg) |-> wb_dat_o[15:0] == cval_reg)
    else $error("coefficient readback wrong");
  a_lane_after_sample: assert property (lanes_o.valid |-> $past(samples_i.valid, 2))
    else $error("lane valid without sample");
  a_lane_hold: assert property (!lanes_o.valid |-> $stable(lanes_o.word))
    else $error("lane words moved between valids");
  a_pass_through: assert property ((lanes_o.valid && ctrl_reg[1:0] == 2'b00)
    |-> lanes_o.word == s2_reg)
    else $error("plain lane words wrong");
  a_pair_lane1: assert property ((lanes_o.valid && ctrl_reg[1:0] == 2'b10
    && sel_reg[1:0] == 2'b10) |-> lanes_o.word[0] == pair_sum[12:1])
    else $error("lane 1 pair average wrong");
  a_quad_lane8: assert property ((lanes_o.valid && ctrl_reg[1:0] == 2'b10
    && sel_reg[15:14] == 2'b11) |-> lanes_o.word[7] == quad_sum[13:2])
    else $error("lane 8 quad average wrong");
  c_avg_lane: cover property (lanes_o.valid && ctrl_reg[1]);
  c_fir_lane: cover property (lanes_o.valid && ctrl_reg[0]);
  c_read_ack: cover property (wb_ack_o && !wb_we_i);
endmodule

bind adc_post_top adc_post_monitor mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .samples_i(samples_i), .lanes_o(lanes_o));

// >>> sim/lane_receiver.sv
// far-side capture model: keeps every lane word set in arrival order
// assumes lane words are qualified by their one-cycle valid pulse
`timescale 1ns/10ps
module lane_receiver
  import adc_post_pkg::*;
(
  input wire logic      clk_i,
  input wire logic      rst_i,
  input wire lane_bus_t lanes_i
);
  logic [NUM_CH*DATA_W-1:0] q[$];
  always @(posedge clk_i)
    if (!rst_i && lanes_i.valid)
      q.push_back(lanes_i.word);
endmodule

// >>> sim/adc_post_top_tb.sv
// self-checking bench: register bus, random sample streams, fir and averaging
// assumes one 40 MHz clock and the lane receiver model
`timescale 1ns/10ps
module adc_post_top_tb
  import adc_post_pkg::*;
;
  logic        clk_i = 0;
  logic        rst_i = 1;
  logic        cyc = 0;
  logic        stb = 0;
  logic        we = 0;
  logic [9:0]  adr = 0;
  logic [31:0] dat_w = 0;
  logic [31:0] dat_r;
  logic        ack;
  sample_bus_t samples = '0;
  lane_bus_t   lanes;
  int          seed = 23667;
  int          n_mismatch = 0;
  int          checks = 0;
  int          h[8][12];
  int          hist[8][24];
  logic [95:0] exp_q[$];
  bit          chk_q[$];
  int btab[6][12] = '{'{3, 0, 5, 1, -27, -2, 73, 3, -178, -4, 636, 1024},
    '{-22, -65, -52, 30, 66, -35, -107, 38, 202, -41, -644, 1061},
    '{-17, -50, 71, 46, 24, -42, -100, -97, 8, 202, 414, 554},
    '{-7, 19, -47, 127, 73, 0, 86, 117, -190, -464, -113, 526},
    '{-34, -34, -101, 43, 58, -28, -5, -179, 294, 86, -563, 352},
    '{40, -15, -95, 22, -8, -81, 106, -62, -97, 310, -501, 575}};
  int dcode[8] = '{0, 0, 1, 1, 1, 1, 4, 3};
  int dfac[8]  = '{2, 2, 4, 4, 4, 4, 8, 1};
  int oddv[8]  = '{1, 1, 0, 0, 0, 1, 0, 0};
  adc_post_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
    .wb_ack_o(ack), .samples_i(samples), .lanes_o(lanes));
  lane_receiver rx (.clk_i(clk_i), .rst_i(rst_i), .lanes_i(lanes));
  initial
  begin
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic stop_test;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] i, input logic [15:0] d,
                    output logic [31:0] q);
    int n;
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= {i, 2'b00}; dat_w <= {16'h0000, d};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dat_r;
    cyc <= 0; stb <= 0;
    if (n >= 20)
      chk(0, 1);
  endtask
  function automatic logic [11:0] fir_ref(input int c, input int dc, input int odd);
    int acc, w;
    acc = 0;
    for (int t = 0; t < 24; t++)
    begin
      if (dc == 3) w = (t < 6) ? h[c][6+t] : (t < 12) ? h[c][17-t] : 0;
      else if (odd) w = (t < 12) ? h[c][t] : (t < 23) ? h[c][22-t] : 0;
      else w = (t < 12) ? h[c][t] : h[c][23-t];
      acc += w * hist[c][t];
    end
    acc = acc >>> 11;
    if (acc > 2047) acc = 2047;
    if (acc < -2048) acc = -2048;
    return 12'(acc);
  endfunction
  function automatic logic [95:0] lane_ref(input logic [95:0] x, input logic [15:0] s);
    int v[8], b, k, p0, p1, q4;
    for (int c = 0; c < 8; c++) v[c] = $signed(x[c*12+:12]);
    for (int l = 0; l < 8; l++)
    begin
      b = l / 4 * 4; k = l % 4;
      p0 = (v[b] + v[b+1]) >>> 1;
      p1 = (v[b+2] + v[b+3]) >>> 1;
      q4 = (v[b] + v[b+1] + v[b+2] + v[b+3]) >>> 2;
      lane_ref[l*12+:12] = 12'(s[2*l+:2] == 0 ? v[l] : (k == 0 || k == 3)
        && s[2*l+:2] == 3 ? q4 : (k == 0 || k == 2) ? p0 : p1);
    end
  endfunction
  task automatic stream(input int n, input int d, input int dc, input int odd,
                        input logic [15:0] s, input bit fir);
    logic [95:0] x, e, got;
    int ph;
    ph = 0;
    for (int k = 0; k < n; k++)
    begin
      for (int c = 0; c < 8; c++) x[c*12+:12] = 12'($random(seed));
      @(posedge clk_i);
      samples <= {1'b1, x};
      for (int c = 0; c < 8; c++)
      begin
        for (int t = 23; t > 0; t--) hist[c][t] = hist[c][t-1];
        hist[c][0] = $signed(x[c*12+:12]);
        e[c*12+:12] = fir_ref(c, dc, odd);
      end
      if (ph == d - 1)
      begin
        exp_q.push_back(fir ? e : lane_ref(x, s));
        chk_q.push_back(!fir || k >= 23);
      end
      ph = (ph + 1) % d;
    end
    @(posedge clk_i);
    samples.valid <= 0;
    repeat (4) @(posedge clk_i);
    chk(96'(rx.q.size()), 96'(exp_q.size()));
    while (exp_q.size() > 0 && rx.q.size() > 0)
    begin
      e = exp_q.pop_front();
      got = rx.q.pop_front();
      if (chk_q.pop_front()) chk(got, e);
    end
    exp_q.delete(); chk_q.delete(); rx.q.delete();
  endtask
  initial
  begin
    logic [31:0] r;
    logic [15:0] s;
    logic [11:0] v;
    int odd;
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    wb(0, 8'h20, 16'h0000, r);
    chk(96'(r), 96'(0));
    for (int c = 0; c < 8; c++)
    begin
      wb(1, 8'(CHCFG_IDX + c), 16'h5400, r);
      wb(0, 8'(CHCFG_IDX + c), 16'h0000, r);
      chk(96'(r), 96'(16'h5400));
      wb(1, 8'(CHCFG_IDX + c), 16'h0000, r);
    end
    stream(20, 1, 0, 0, 16'h0000, 0);
    for (int a = 0; a < 6; a++)
    begin
      s = a == 0 ? 16'hbebe : a == 1 ? 16'hc3c3 : 16'($random(seed));
      for (int l = 0; l < 8; l++)
        if (s[2*l+:2] == 1 || (s[2*l+:2] == 2 && (l % 4 == 1 || l % 4 == 2)))
          s[2*l+:2] = 2'b00;
      wb(1, AVGSEL_IDX, s, r);
      wb(1, CTRL_IDX, 16'h0002, r);
      stream(16, 1, 0, 0, s, 0);
    end
    for (int sc = 0; sc < 8; sc++)
    begin
      odd = sc == 6 ? $random(seed) & 1 : oddv[sc];
      for (int c = 0; c < 8; c++)
      begin
        wb(1, 8'(CHCFG_IDX + c), 16'(16 + odd * 8 + (sc < 6 ? sc : 0)), r);
        for (int i = 0; i < 12; i++)
        begin
          v = 12'($random(seed));
          h[c][i] = sc < 6 ? btab[sc][i] : $signed(v);
          if (sc >= 6) wb(1, 8'(COEF_IDX + c * 12 + i), {4'h8, v}, r);
        end
      end
      if (sc >= 6)
      begin
        wb(0, 8'(COEF_IDX + 95), 16'h0000, r);
        chk(96'(r), 96'({4'h8, v}));
      end
      wb(1, CTRL_IDX, 16'(dcode[sc] * 16 + 1), r);
      stream(64, dfac[sc], dcode[sc], odd, 16'h0000, 1);
    end
    stop_test();
  end
  initial
  begin
    #1500000;
    n_mismatch++;
    stop_test();
  end
endmodule
